/* File: inc/jk_bank_defs.svh */
`ifndef JK_BANK_DEFS_SVH
`define JK_BANK_DEFS_SVH

`define FF_COUNT          6
`define CLK_PERIOD_NS     5
`define RESET_MIN_NS      25
`define RESET_MIN_CYC     ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define GRP1_MASK_3_3     6'h07
`define GRP1_MASK_4_2     6'h03
`define GRP1_MASK_5_1     6'h01
`define GRP1_MASK_6_0     6'h3F
`define GRP1_MASK_RESET   6'h07

`endif

/* File: inc/jk_bank_pkg.sv */
`include "jk_bank_defs.svh"

package jk_bank_pkg;

    typedef enum logic [1:0] {
        GRP_3_3,
        GRP_4_2,
        GRP_5_1,
        GRP_6_0
    } group_cfg_e;

    typedef struct packed {
        logic [`FF_COUNT-1:0] j;
        logic [`FF_COUNT-1:0] k;
        logic [`FF_COUNT-1:0] pulse;
        logic [`FF_COUNT-1:0] rst_n;
    } ff_in_s;

    typedef struct packed {
        logic [`FF_COUNT-1:0] q;
        logic [`FF_COUNT-1:0] qn;
    } ff_out_s;

endpackage

/* File: logic/jk_cell.sv */
`timescale 1ns/100ps

module jk_cell (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic pulse_i,
    input  wire logic j_i,
    input  wire logic k_i,
    input  wire logic clear_n_i,
    output logic      q_o,
    output logic      qn_o
);
    logic pulse_d_ff;
    logic j_ff;
    logic k_ff;
    logic q_ff;
    logic qn_ff;
    logic nxt_j;
    logic nxt_k;
    logic nxt_q;
    logic nxt_qn;
    logic rise;
    logic fall;

    always_comb begin
        rise  = pulse_i & ~pulse_d_ff;
        fall  = ~pulse_i & pulse_d_ff;
        // inputs sampled at the leading edge
        nxt_j = rise ? j_i : j_ff;
        nxt_k = rise ? k_i : k_ff;
        nxt_q = q_ff;
        if (!clear_n_i) begin
            nxt_q = 1'b0;
        end else if (fall) begin
            if (q_ff) begin
                nxt_q = ~k_ff;
            end else begin
                nxt_q = j_ff;
            end
        end
        nxt_qn = ~nxt_q;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pulse_d_ff <= 1'b0;
            j_ff       <= 1'b0;
            k_ff       <= 1'b0;
            q_ff       <= 1'b0;
            qn_ff      <= 1'b1;
        end else begin
            pulse_d_ff <= pulse_i;
            j_ff       <= nxt_j;
            k_ff       <= nxt_k;
            q_ff       <= nxt_q;
            qn_ff      <= nxt_qn;
        end
    end

    assign q_o  = q_ff;
    assign qn_o = qn_ff;
endmodule

/* File: logic/jk_bank.sv */
`timescale 1ns/100ps
`include "jk_bank_defs.svh"

//Contract
// - Six independent J-K flip-flops serve as buffers, control bits, shift or count stages.
// - At pulse end a zero sets if J is high, a one clears if K is high, else state holds.
// - With J and K both high the flip-flop toggles on every clock pulse.
// - New state shows after the pulse's falling edge, never at its rising edge.
// - A low reset held at least 25 ns zeroes its flip-flop whatever the clock, J and K.
// - Two group clear lines cover the six flip-flops, jumpered as 3/3, 4/2, 5/1 or 6/0.
// - By default clear line 1 resets flip-flops 0 to 2 and clear line 2 resets 3 to 5.
// - In 4/2 line 1 clears 0-1 and line 2 clears 2-5; in 5/1 line 1 clears only 0.
module jk_bank #(
    parameter int NUM_FF = `FF_COUNT
) (
    input  wire logic                   clk_i,
    input  wire logic                   resetn_i,
    input  wire jk_bank_pkg::ff_in_s    ff_i,
    input  wire logic                   clear1_n_i,
    input  wire logic                   clear2_n_i,
    input  wire jk_bank_pkg::group_cfg_e group_cfg_i,
    output jk_bank_pkg::ff_out_s        ff_o
);
    import jk_bank_pkg::*;

    logic [NUM_FF-1:0] grp1_mask_ff;
    logic [NUM_FF-1:0] nxt_grp1_mask;
    logic [NUM_FF-1:0] clear_n;
    logic [NUM_FF-1:0] q_w;
    logic [NUM_FF-1:0] qn_w;

    // jumper split decode
    always_comb begin
        unique case (group_cfg_i)
            GRP_3_3: nxt_grp1_mask = NUM_FF'(`GRP1_MASK_3_3);
            GRP_4_2: nxt_grp1_mask = NUM_FF'(`GRP1_MASK_4_2);
            GRP_5_1: nxt_grp1_mask = NUM_FF'(`GRP1_MASK_5_1);
            GRP_6_0: nxt_grp1_mask = NUM_FF'(`GRP1_MASK_6_0);
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            grp1_mask_ff <= NUM_FF'(`GRP1_MASK_RESET);
        end else begin
            grp1_mask_ff <= nxt_grp1_mask;
        end
    end

    always_comb begin
        for (int n = 0; n < NUM_FF; n++) begin
            // own reset combined with the selected group line
            clear_n[n] = ff_i.rst_n[n] &
                         (grp1_mask_ff[n] ? clear1_n_i : clear2_n_i);
        end
    end

    for (genvar g = 0; g < NUM_FF; g++) begin : g_ff
        jk_cell u_cell (
            .clk_i    (clk_i),
            .resetn_i (resetn_i),
            .pulse_i  (ff_i.pulse[g]),
            .j_i      (ff_i.j[g]),
            .k_i      (ff_i.k[g]),
            .clear_n_i(clear_n[g]),
            .q_o      (q_w[g]),
            .qn_o     (qn_w[g])
        );
    end

    assign ff_o = {q_w, qn_w};

    // helper capture of J and K at the leading edge, read only by checks
    logic [NUM_FF-1:0] chk_j_ff;
    logic [NUM_FF-1:0] chk_k_ff;
    logic [NUM_FF-1:0] chk_pulse_ff;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            chk_j_ff     <= '0;
            chk_k_ff     <= '0;
            chk_pulse_ff <= '0;
        end else begin
            chk_pulse_ff <= ff_i.pulse;
            for (int n = 0; n < NUM_FF; n++) begin
                if (ff_i.pulse[n] && !chk_pulse_ff[n]) begin
                    chk_j_ff[n] <= ff_i.j[n];
                    chk_k_ff[n] <= ff_i.k[n];
                end
            end
        end
    end

    for (genvar a = 0; a < NUM_FF; a++) begin : g_chk
        sequence s_rise;
            !ff_i.pulse[a] ##1 ff_i.pulse[a];
        endsequence

        sequence s_fall;
            chk_pulse_ff[a] && !ff_i.pulse[a];
        endsequence

        property p_set_from_zero;
            @(posedge clk_i) disable iff (!resetn_i)
            s_fall and (clear_n[a] && !q_w[a] && chk_j_ff[a]) |=> q_w[a];
        endproperty
        a_set_from_zero: assert property (p_set_from_zero)
            else $error("zero with J high did not become one at pulse end");

        property p_reset_from_one;
            @(posedge clk_i) disable iff (!resetn_i)
            s_fall and (clear_n[a] && q_w[a] && chk_k_ff[a]) |=> !q_w[a];
        endproperty
        a_reset_from_one: assert property (p_reset_from_one)
            else $error("one with K high did not become zero at pulse end");

        property p_hold;
            @(posedge clk_i) disable iff (!resetn_i)
            s_fall and clear_n[a] && (q_w[a] ? !chk_k_ff[a] : !chk_j_ff[a])
            |=> q_w[a] == $past(q_w[a]);
        endproperty
        a_hold: assert property (p_hold)
            else $error("flip-flop changed without enabling input");

        property p_toggle;
            @(posedge clk_i) disable iff (!resetn_i)
            s_fall and (clear_n[a] && chk_j_ff[a] && chk_k_ff[a])
            |=> q_w[a] != $past(q_w[a]);
        endproperty
        a_toggle: assert property (p_toggle)
            else $error("J and K high did not toggle");

        property p_no_change_at_rise;
            @(posedge clk_i) disable iff (!resetn_i)
            s_rise ##0 (clear_n[a] && $past(clear_n[a]))
            |=> q_w[a] == $past(q_w[a]);
        endproperty
        a_no_change_at_rise: assert property (p_no_change_at_rise)
            else $error("output moved at leading edge");

        property p_steady_high;
            @(posedge clk_i) disable iff (!resetn_i)
            (ff_i.pulse[a] && chk_pulse_ff[a] && clear_n[a])
            |=> q_w[a] == $past(q_w[a]);
        endproperty
        a_steady_high: assert property (p_steady_high)
            else $error("output moved while clock pulse high");

        property p_reset_min;
            @(posedge clk_i) disable iff (!resetn_i)
            (!ff_i.rst_n[a]) [*5] |-> ##1 (!q_w[a] && qn_w[a]);
        endproperty
        a_reset_min: assert property (p_reset_min)
            else $error("reset held 25 ns did not clear flip-flop");

        property p_clear_wins;
            @(posedge clk_i) disable iff (!resetn_i)
            !clear_n[a] ##1 !clear_n[a] |-> !q_w[a] ##1 ($past(clear_n[a]) || !q_w[a]);
        endproperty
        a_clear_wins: assert property (p_clear_wins)
            else $error("clock activity moved a cleared flip-flop");

        property p_complement;
            @(posedge clk_i) disable iff (!resetn_i)
            $changed(q_w[a]) |-> (q_w[a] != qn_w[a]) && $changed(qn_w[a]);
        endproperty
        a_complement: assert property (p_complement)
            else $error("true and complement outputs not opposite");
    end

    property p_group_3_3;
        @(posedge clk_i) disable iff (!resetn_i)
        (grp1_mask_ff == NUM_FF'(`GRP1_MASK_3_3)) && !clear1_n_i && clear2_n_i
        && (&ff_i.rst_n) |=> (q_w[2:0] == 3'h0);
    endproperty
    a_group_3_3: assert property (p_group_3_3)
        else $error("first clear line missed flip-flops 0 to 2");

    property p_group_4_2;
        @(posedge clk_i) disable iff (!resetn_i)
        (grp1_mask_ff == NUM_FF'(`GRP1_MASK_4_2)) && clear1_n_i && !clear2_n_i
        && (&ff_i.rst_n) |=> (q_w[5:2] == 4'h0);
    endproperty
    a_group_4_2: assert property (p_group_4_2)
        else $error("second clear line missed flip-flops 2 to 5");

    property p_group_5_1;
        @(posedge clk_i) disable iff (!resetn_i)
        (grp1_mask_ff == NUM_FF'(`GRP1_MASK_5_1)) && !clear1_n_i && clear2_n_i
        && (&ff_i.rst_n) && ff_i.pulse[1] && !chk_pulse_ff[1] ##1 !ff_i.pulse[1]
        && clear2_n_i && (&ff_i.rst_n) && chk_j_ff[1] && !q_w[1] |=> q_w[1];
    endproperty
    a_group_5_1: assert property (p_group_5_1)
        else $error("first clear line reached beyond flip-flop 0");

    property p_mask_follows;
        @(posedge clk_i) disable iff (!resetn_i)
        (group_cfg_i == GRP_6_0) |=> (grp1_mask_ff == NUM_FF'(`GRP1_MASK_6_0));
    endproperty
    a_mask_follows: assert property (p_mask_follows)
        else $error("six-none split not applied");
endmodule

/* File: tb/jk_driver.sv */
`timescale 1ns/100ps
`include "jk_bank_defs.svh"

module jk_driver (
    input  wire logic                 clk_i,
    input  wire logic [`FF_COUNT-1:0] go_i,
    input  wire logic [`FF_COUNT-1:0] j_i,
    input  wire logic [`FF_COUNT-1:0] k_i,
    input  wire logic [1:0]           hold_i,
    input  wire logic [`FF_COUNT-1:0] rst_req_i,
    output jk_bank_pkg::ff_in_s       ff_o
);
    import jk_bank_pkg::*;

    int hi_cnt [`FF_COUNT];
    int rs_cnt [`FF_COUNT];

    initial begin
        ff_o = '0;
        ff_o.rst_n = '1;
    end

    always @(posedge clk_i) begin
        for (int n = 0; n < `FF_COUNT; n++) begin
            if (rst_req_i[n]) begin
                rs_cnt[n] = `RESET_MIN_CYC;
            end
            ff_o.rst_n[n] <= (rs_cnt[n] == 0);
            if (rs_cnt[n] > 0) begin
                rs_cnt[n]--;
            end
            if (ff_o.pulse[n] && hi_cnt[n] > 0) begin
                hi_cnt[n]--;
            end else if (ff_o.pulse[n]) begin
                ff_o.pulse[n] <= 1'b0;
            end else if (go_i[n]) begin
                ff_o.pulse[n] <= 1'b1;
                ff_o.j[n] <= j_i[n];
                ff_o.k[n] <= k_i[n];
                hi_cnt[n] = hold_i;
            end else begin
                // idle inputs wander so a late sample shows up
                ff_o.j[n] <= ~ff_o.j[n];
                ff_o.k[n] <= ~ff_o.k[n];
            end
        end
    end
endmodule

/* File: tb/jk_bank_bench.sv */
`timescale 1ns/100ps
`include "jk_bank_defs.svh"

module jk_bank_bench;
    import jk_bank_pkg::*;

    logic                 clk;
    logic                 resetn;
    logic                 clear1_n;
    logic                 clear2_n;
    group_cfg_e           group_cfg;
    logic [`FF_COUNT-1:0] go;
    logic [`FF_COUNT-1:0] j_cmd;
    logic [`FF_COUNT-1:0] k_cmd;
    logic [`FF_COUNT-1:0] rst_req;
    logic [1:0]           hold;
    ff_in_s               ff_in;
    ff_out_s              ff_out;
    int                   n_errors;
    int                   check_count;
    int                   mq [`FF_COUNT];
    int                   mj [`FF_COUNT];
    int                   mk [`FF_COUNT];
    int                   mprev [`FF_COUNT];
    int                   mcfg;
    int                   grp1_size [4] = '{3, 2, 1, 6};

    jk_driver i_drv (.clk_i(clk), .go_i(go), .j_i(j_cmd), .k_i(k_cmd), .hold_i(hold),
                     .rst_req_i(rst_req), .ff_o(ff_in));
    jk_bank #(.NUM_FF(`FF_COUNT)) i_dut (.clk_i(clk), .resetn_i(resetn), .ff_i(ff_in),
        .clear1_n_i(clear1_n), .clear2_n_i(clear2_n), .group_cfg_i(group_cfg), .ff_o(ff_out));

    always @(posedge clk or negedge resetn) begin
        bit clr;
        if (!resetn) begin
            mcfg = 0;
            mq = '{default: 0};
            mprev = '{default: 0};
        end else begin
            for (int n = 0; n < `FF_COUNT; n++) begin
                clr = !ff_in.rst_n[n] || !(n < grp1_size[mcfg] ? clear1_n : clear2_n);
                if (clr) begin
                    mq[n] = 0;
                end else if (mprev[n] == 1 && !ff_in.pulse[n]) begin
                    mq[n] = (mq[n] == 1) ? 1 - mk[n] : mj[n];
                end
                if (mprev[n] == 0 && ff_in.pulse[n]) begin
                    mj[n] = ff_in.j[n];
                    mk[n] = ff_in.k[n];
                end
                mprev[n] = ff_in.pulse[n];
            end
            mcfg = int'(group_cfg);
        end
    end

    function automatic logic [`FF_COUNT-1:0] exp_vec();
        logic [`FF_COUNT-1:0] v;
        for (int n = 0; n < `FF_COUNT; n++) begin
            v[n] = mq[n][0];
        end
        return v;
    endfunction

    task automatic cmp_q(input logic [`FF_COUNT-1:0] got, input logic [`FF_COUNT-1:0] want);
        check_count++;
        if (got !== want) begin
            n_errors++;
            $display("unexpected q at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic cmp_qn(input logic [`FF_COUNT-1:0] got, input logic [`FF_COUNT-1:0] want);
        check_count++;
        if (got !== want) begin
            n_errors++;
            $display("unexpected qn at %0t: got %h want %h", $time, got, want);
        end
    endtask

    always @(negedge clk) begin
        cmp_q(ff_out.q, exp_vec());
        cmp_qn(ff_out.qn, ~exp_vec());
    end

    task automatic pulse_all(input logic [`FF_COUNT-1:0] j, input logic [`FF_COUNT-1:0] k);
        @(posedge clk);
        go <= '1;
        j_cmd <= j;
        k_cmd <= k;
        hold <= 2'd0;
        @(posedge clk);
        go <= '0;
        repeat (4) @(posedge clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end

    initial begin
        resetn = 1'b0;
        clear1_n = 1'b1;
        clear2_n = 1'b1;
        group_cfg = GRP_3_3;
        go = '0;
        j_cmd = '0;
        k_cmd = '0;
        rst_req = '0;
        hold = '0;
        n_errors = 0;
        check_count = 0;
        void'($urandom(75));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        repeat (400) begin
            @(posedge clk);
            go <= `FF_COUNT'($urandom);
            j_cmd <= `FF_COUNT'($urandom);
            k_cmd <= `FF_COUNT'($urandom);
            hold <= 2'($urandom);
        end
        @(posedge clk);
        go <= '0;
        repeat (8) @(posedge clk);
        // toggle pulse ends while flip-flops 0-2 are held in clear and 4-5 in reset
        go <= '1;
        j_cmd <= '1;
        k_cmd <= '1;
        hold <= 2'd3;
        @(posedge clk);
        go <= '0;
        @(posedge clk);
        rst_req <= 6'h30;
        clear1_n <= 1'b0;
        @(posedge clk);
        rst_req <= '0;
        repeat (8) @(posedge clk);
        clear1_n <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            group_cfg <= group_cfg_e'(c);
            for (int line = 0; line < 2; line++) begin
                pulse_all('1, '0);
                clear1_n <= (line != 0);
                clear2_n <= (line == 0);
                repeat (`RESET_MIN_CYC) @(posedge clk);
                clear1_n <= 1'b1;
                clear2_n <= 1'b1;
            end
        end
        // only flip-flop 0 follows line 1 in the five-one split
        @(posedge clk);
        group_cfg <= GRP_5_1;
        clear2_n <= 1'b0;
        repeat (`RESET_MIN_CYC) @(posedge clk);
        clear2_n <= 1'b1;
        clear1_n <= 1'b0;
        pulse_all('1, '0);
        clear1_n <= 1'b1;
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule
